// file: rtl/camera_identity_status.v
// Identity, feature and status register bank on APB; only the interrupt enable and clear registers are writable.
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
`include "camera_identity_status_regs.vh"
// Overview of operation
// - Feature words report presence in bit zero.
// - Firmware versions as BCD in bits 16-31.
// - Camera type code in logic word bits 0-15.
// - Extended versions: special, major, minor, patch.
// - All-zero extended words mean unsupported.
// - Eight ASCII ordering bytes, upper word first.
// - Named feature bits set when feature present.
// - Main word: resolution bit 0 to buffer 31.
// - IO word lines, delay, PWM; misc word storage bit 15.
// - Status idle bit 31, isochronous bit 28.
// - Status bit 15 shows external trigger armed.
// - Status polls under 5 ms are delayed.
// - Header: presence bit 0, ID bits 24-31.
module camera_identity_status #(
  parameter [15:0] CTRL_VERSION = 16'h0110,
  parameter [15:0] LOGIC_VERSION = 16'h0085,
  // Camera type code; the value is arbitrary.
  parameter [15:0] CAMERA_TYPE = 16'h0A5C,
  // Extended versions; zero reports that they are unsupported.
  parameter [31:0] CTRL_VERSION_EXT = 32'h0000_0000,
  parameter [31:0] LOGIC_VERSION_EXT = 32'h0000_0000,
  // Ordering code; the value is arbitrary.
  parameter [63:0] ORDER_CODE = 64'h4142_4344_3132_3334,
  parameter [31:0] FEAT_MAIN = 32'hFFFF_FFFF,
  parameter [31:0] FEAT_IO = 32'hFFFF_FFFF,
  parameter [31:0] FEAT_MISC = 32'hFFFF_FFFF,
  parameter [31:0] FEAT_EXTRA = 32'h0000_0000,
  // Implementation code of the status block; the value is arbitrary.
  parameter [7:0] IMPL_ID = 8'h5A,
  parameter integer STATUS_GAP_CYCLES = `STATUS_GAP_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire camera_idle,
  input wire iso_active,
  input wire external_trigger_armed,
  output wire irq
);

  // Maps a bit number counted from the most significant end.
  function [4:0] msb_pos;
    input integer n;
    begin
      msb_pos = 5'd31 - n[4:0];
    end
  endfunction

  // Places one flag at a position counted from the top.
  function [31:0] flag_at;
    input integer n;
    input flag;
    begin
      flag_at = 32'h0000_0000;
      flag_at[msb_pos(n)] = flag;
    end
  endfunction

  reg [`EVT_WIDTH-1:0] evt_status_r;
  reg [`EVT_WIDTH-1:0] evt_status_nxt;
  reg [`EVT_WIDTH-1:0] evt_enable_r;
  reg [`EVT_WIDTH-1:0] evt_enable_nxt;
  reg idle_prev_r;
  reg iso_prev_r;
  reg trig_prev_r;
  reg [19:0] gap_cnt_r;
  reg [19:0] gap_cnt_nxt;
  reg polled_r;
  reg waited_r;
  reg [31:0] rd_mux;
  reg mapped;
  reg is_status;

  wire setup_phase;
  wire access_phase;
  wire gap_ok;
  wire status_wait;
  wire done;
  wire wr_done;
  wire [`EVT_WIDTH-1:0] evt_set;
  wire [`EVT_WIDTH-1:0] clr_mask;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;

  // Address decode and read data; the status flags word is built from live inputs.
  always @* begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    is_status = 1'b0;
    case (paddr)
      `ADDR_CTRL_VER_SHORT: begin
        rd_mux = {16'h0000, CTRL_VERSION};
      end
      `ADDR_CTRL_VER_EXT: begin
        rd_mux = CTRL_VERSION_EXT;
      end
      `ADDR_LOGIC_VER_TYPE: begin
        rd_mux = {CAMERA_TYPE, LOGIC_VERSION};
      end
      `ADDR_LOGIC_VER_EXT: begin
        rd_mux = LOGIC_VERSION_EXT;
      end
      `ADDR_RSVD_A, `ADDR_RSVD_B, `ADDR_RSVD_C, `ADDR_RSVD_D: begin
        rd_mux = 32'h0000_0000;
      end
      `ADDR_ORDER_UPPER: begin
        rd_mux = ORDER_CODE[63:32];
      end
      `ADDR_ORDER_LOWER: begin
        rd_mux = ORDER_CODE[31:0];
      end
      `ADDR_FEAT_MAIN: begin
        rd_mux = FEAT_MAIN & `MASK_FEAT_MAIN;
      end
      `ADDR_FEAT_IO: begin
        rd_mux = FEAT_IO & `MASK_FEAT_IO;
      end
      `ADDR_FEAT_MISC: begin
        rd_mux = FEAT_MISC & `MASK_FEAT_MISC;
      end
      `ADDR_FEAT_EXTRA: begin
        rd_mux = FEAT_EXTRA;
      end
      `ADDR_STATE_HEADER: begin
        is_status = 1'b1;
        rd_mux = flag_at(`POS_PRESENCE, 1'b1) |
          {24'h00_0000, IMPL_ID};
      end
      `ADDR_STATE_FLAGS: begin
        is_status = 1'b1;
        rd_mux = flag_at(`POS_IDLE, camera_idle) |
          flag_at(`POS_ISO_ACTIVE, iso_active) |
          flag_at(`POS_TRIGGER_ARMED, external_trigger_armed);
      end
      `ADDR_EVENT_STATUS: begin
        rd_mux = {28'h000_0000, evt_status_r};
      end
      `ADDR_EVENT_CLEAR: begin
        rd_mux = 32'h0000_0000;
      end
      `ADDR_EVENT_ENABLE: begin
        rd_mux = {28'h000_0000, evt_enable_r};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Status polls closer together than the gap are held until it has run.
  assign gap_ok = ~polled_r |
    (gap_cnt_r >= STATUS_GAP_CYCLES[19:0] - 20'd1);
  assign status_wait = psel & is_status & ~pwrite & ~gap_ok;
  assign pready = ~status_wait;
  assign pslverr = access_phase & ~mapped;
  assign done = access_phase & pready;
  // Writes complete on any mapped register; only the enable and clear registers use the data.
  assign wr_done = done & pwrite & mapped;

  always @* begin
    gap_cnt_nxt = gap_cnt_r;
    if (done & is_status & ~pwrite) begin
      gap_cnt_nxt = `RST_GAP_CNT;
    end else if (~gap_ok) begin
      gap_cnt_nxt = gap_cnt_r + 20'd1;
    end
  end

  assign evt_set[`EVT_IDLE] = camera_idle & ~idle_prev_r;
  assign evt_set[`EVT_ISO] = iso_active & ~iso_prev_r;
  assign evt_set[`EVT_TRIGGER] = external_trigger_armed & ~trig_prev_r;
  assign evt_set[`EVT_SLOW_POLL] = access_phase & status_wait & ~waited_r;
  assign clr_mask = (wr_done && paddr == `ADDR_EVENT_CLEAR && pstrb[0]) ?
    pwdata[`EVT_WIDTH-1:0] : `RST_EVENTS;

  // Sticky events: a new event wins over a clear in the same cycle.
  always @* begin
    evt_status_nxt = (evt_status_r & ~clr_mask) | evt_set;
    evt_enable_nxt = evt_enable_r;
    if (wr_done && paddr == `ADDR_EVENT_ENABLE && pstrb[0]) begin
      evt_enable_nxt = pwdata[`EVT_WIDTH-1:0];
    end
  end

  assign irq = |(evt_status_r & evt_enable_r);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status_r <= `RST_EVENTS;
      evt_enable_r <= `RST_EVENTS;
      idle_prev_r <= 1'b0;
      iso_prev_r <= 1'b0;
      trig_prev_r <= 1'b0;
      gap_cnt_r <= `RST_GAP_CNT;
      polled_r <= 1'b0;
      waited_r <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      evt_status_r <= evt_status_nxt;
      evt_enable_r <= evt_enable_nxt;
      idle_prev_r <= camera_idle;
      iso_prev_r <= iso_active;
      trig_prev_r <= external_trigger_armed;
      gap_cnt_r <= gap_cnt_nxt;
      if (done & is_status & ~pwrite) begin
        polled_r <= 1'b1;
      end
      waited_r <= access_phase & status_wait;
      if ((setup_phase | status_wait) & ~pwrite) begin
        prdata <= rd_mux;
      end else if (done) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule // camera_identity_status

// file: rtl/camera_identity_status_regs.vh
// Register map, field layouts and timing constants of the identity bank.
`ifndef CAMERA_IDENTITY_STATUS_REGS_VH
`define CAMERA_IDENTITY_STATUS_REGS_VH

// Byte addresses of the registers.
`define ADDR_CTRL_VER_SHORT 32'hF100_0010
`define ADDR_CTRL_VER_EXT 32'hF100_0014
`define ADDR_LOGIC_VER_TYPE 32'hF100_0018
`define ADDR_LOGIC_VER_EXT 32'hF100_001C
`define ADDR_RSVD_A 32'hF100_0020
`define ADDR_RSVD_B 32'hF100_0024
`define ADDR_RSVD_C 32'hF100_0028
`define ADDR_RSVD_D 32'hF100_002C
`define ADDR_ORDER_UPPER 32'hF100_0030
`define ADDR_ORDER_LOWER 32'hF100_0034
`define ADDR_FEAT_MAIN 32'hF100_0040
`define ADDR_FEAT_IO 32'hF100_0044
`define ADDR_FEAT_MISC 32'hF100_0048
`define ADDR_FEAT_EXTRA 32'hF100_004C
`define ADDR_STATE_HEADER 32'hF100_0100
`define ADDR_STATE_FLAGS 32'hF100_0104
`define ADDR_EVENT_STATUS 32'hF100_0110
`define ADDR_EVENT_CLEAR 32'hF100_0114
`define ADDR_EVENT_ENABLE 32'hF100_0118

// Field positions, numbered with 0 as the most significant bit.
`define POS_PRESENCE 0
`define POS_TRIGGER_ARMED 15
`define POS_ISO_ACTIVE 28
`define POS_IDLE 31

// Masks of the named feature bits, in Verilog bit order.
`define MASK_FEAT_MAIN 32'hFEF3_E403
`define MASK_FEAT_IO 32'hC0F0_80F0
`define MASK_FEAT_MISC 32'hFE01_0000

// Event bits of the interrupt registers.
`define EVT_IDLE 0
`define EVT_ISO 1
`define EVT_TRIGGER 2
`define EVT_SLOW_POLL 3
`define EVT_WIDTH 4

// Reset values.
`define RST_EVENTS 4'h0
`define RST_GAP_CNT 20'h0_0000

// Timing of status polls.
`define CLK_PERIOD_NS 20
`define STATUS_GAP_MS 5
`define STATUS_GAP_CYCLES (`STATUS_GAP_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// file: tb/camera_core_model.sv
// Camera core stand-in that drives the status levels.
`timescale 1ns/1ns
module camera_core_model (
  input wire pclk,
  input wire presetn,
  input wire [2:0] mode,
  output reg camera_idle,
  output reg iso_active,
  output reg external_trigger_armed
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {external_trigger_armed, iso_active, camera_idle} <= 3'b000;
    end else begin
      {external_trigger_armed, iso_active, camera_idle} <= mode;
    end
  end
endmodule // camera_core_model

// file: tb/camera_identity_status_sva.sv
// Assertions on the identity and status bank ports.
`timescale 1ns/1ns
`include "camera_identity_status_regs.vh"
module camera_identity_status_sva #(
  parameter integer STATUS_GAP_CYCLES = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire camera_idle,
  input wire iso_active,
  input wire external_trigger_armed
);
  wire stat_w = paddr == `ADDR_STATE_HEADER || paddr == `ADDR_STATE_FLAGS;
  wire sdone_w = psel && penable && pready && !pwrite && stat_w;
  reg [31:0] gap_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_r <= STATUS_GAP_CYCLES;
    else if (sdone_w) gap_r <= 0;
    else if (gap_r < STATUS_GAP_CYCLES) gap_r <= gap_r + 1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_s(a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  sequence wait_s;
    psel && penable && !pready;
  endsequence
  ctrl_ver_a: assert property (
    rd_s(`ADDR_CTRL_VER_SHORT) |-> prdata == 32'h0000_0110)
    else $error("Controller version wrong.");
  logic_ver_a: assert property (
    rd_s(`ADDR_LOGIC_VER_TYPE) |-> prdata == 32'h0A5C_0085)
    else $error("Logic version wrong.");
  order_hi_a: assert property (
    rd_s(`ADDR_ORDER_UPPER) |-> prdata == 32'h4142_4344)
    else $error("Ordering code wrong.");
  header_id_a: assert property (
    rd_s(`ADDR_STATE_HEADER) |-> prdata == 32'h8000_005A)
    else $error("Status header wrong.");
  flag_bits_a: assert property (
    rd_s(`ADDR_STATE_FLAGS) |-> prdata[0] == $past(camera_idle) &&
    prdata[3] == $past(iso_active) &&
    prdata[16] == $past(external_trigger_armed))
    else $error("Status flags wrong.");
  wait_only_a: assert property (!pready |-> psel && stat_w)
    else $error("Wait on a non-status access.");
  wait_end_a: assert property (wait_s |-> ##[1:1000] pready)
    else $error("Wait never ends.");
  poll_gap_a: assert property (
    sdone_w |-> gap_r >= STATUS_GAP_CYCLES - 1)
    else $error("Status polls too close.");
endmodule // camera_identity_status_sva
bind camera_identity_status camera_identity_status_sva #(
  .STATUS_GAP_CYCLES(STATUS_GAP_CYCLES)) sva_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .prdata(prdata),
  .camera_idle(camera_idle), .iso_active(iso_active),
  .external_trigger_armed(external_trigger_armed));

// file: tb/testbench.sv
// Self-checking bench of the identity and status bank.
`timescale 1ns/1ns
`include "camera_identity_status_regs.vh"
module testbench;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  reg [31:0] paddr = 0, pwdata = 0, q;
  reg [2:0] mode = 0;
  wire pready, pslverr, irq, idle, iso, arm;
  wire [31:0] prdata;
  integer errors = 0, num_checks = 0, n;
  camera_identity_status #(.STATUS_GAP_CYCLES(16)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .camera_idle(idle),
    .iso_active(iso), .external_trigger_armed(arm), .irq(irq));
  camera_core_model core_u (.pclk(pclk), .presetn(presetn), .mode(mode),
    .camera_idle(idle), .iso_active(iso), .external_trigger_armed(arm));
  initial forever #10 pclk = ~pclk;
  task stop_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [63:0] nm, input [31:0] x, g);
    num_checks = num_checks + 1;
    if (g !== x) begin
      errors = errors + 1;
      $display("Error %0s expected %h seen %h", nm, x, g);
    end
  endtask
  task apb(input w, input [31:0] a, d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    @(negedge pclk);
    while (pready !== 1'b1) begin
      n = n + 1;
      @(negedge pclk);
    end
    q = prdata; e = pslverr;
    @(posedge pclk);
    psel <= 0; penable <= 0;
  endtask
  task rc(input [31:0] a, x, input [63:0] nm);
    apb(0, a, 0);
    chk(nm, x, q);
  endtask
  task t_ids;
    rc(`ADDR_CTRL_VER_SHORT, 32'h0000_0110, "cvs");
    rc(`ADDR_LOGIC_VER_TYPE, 32'h0A5C_0085, "lvt");
    rc(`ADDR_LOGIC_VER_EXT, 32'h0000_0000, "lve");
    rc(`ADDR_RSVD_C, 32'h0000_0000, "rsv");
    rc(`ADDR_ORDER_UPPER, 32'h4142_4344, "ohi");
    rc(`ADDR_ORDER_LOWER, 32'h3132_3334, "olo");
    rc(`ADDR_FEAT_MAIN, 32'hFEF3_E403, "fmn");
    rc(`ADDR_FEAT_IO, 32'hC0F0_80F0, "fio");
    rc(`ADDR_FEAT_MISC, 32'hFE01_0000, "fms");
    apb(0, 32'hF100_0038, 0);
    chk("err", 1, e);
    apb(1, `ADDR_ORDER_UPPER, 0);
    chk("werr", 0, e);
    rc(`ADDR_ORDER_UPPER, 32'h4142_4344, "wkeep");
    $display("identity test done");
  endtask
  task t_status;
    mode <= 3'b101;
    repeat (3) @(posedge pclk);
    rc(`ADDR_STATE_HEADER, 32'h8000_005A, "hdr");
    rc(`ADDR_STATE_FLAGS, 32'h0001_0001, "flg");
    chk("slow", 13, n);
    mode <= 3'b010;
    repeat (20) @(posedge pclk);
    rc(`ADDR_STATE_FLAGS, 32'h0000_0008, "iso");
    $display("status test done");
  endtask
  task t_irq;
    mode <= 3'b000;
    apb(1, `ADDR_EVENT_ENABLE, 1);
    apb(1, `ADDR_EVENT_CLEAR, 32'h0000_000F);
    @(negedge pclk);
    chk("irq0", 0, irq);
    @(posedge pclk);
    mode <= 3'b001;
    repeat (3) @(negedge pclk);
    chk("irq1", 1, irq);
    rc(`ADDR_EVENT_STATUS, 1, "evt");
    apb(1, `ADDR_EVENT_ENABLE, 0);
    @(negedge pclk);
    chk("mask", 0, irq);
    rc(`ADDR_EVENT_STATUS, 1, "stky");
    apb(1, `ADDR_EVENT_CLEAR, 1);
    rc(`ADDR_EVENT_STATUS, 0, "clr");
    $display("interrupt test done");
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_ids;
    t_status;
    t_irq;
    stop_test;
  end
  initial begin
    #200000;
    errors = errors + 1;
    stop_test;
  end
endmodule // testbench
